// File: design/wrf_filter.sv
// Wake receive filter: registers, status flags and wake output
`timescale 1ns/1ps
`include "wrf_defines.svh"

// Notes on behaviour
// - clear bit drops level wake, self-clears
// - pulse width 8/16/32/64 wake-clock periods
// - mode bit picks level or pulse wake
// - extended enable gates all detection
// - password check enable qualifies magic frames
// - unicast enable lets unicast raise wake
// - broadcast enable, reset one, raises wake
// - pattern enable lets pattern match wake
// - magic enable lets magic frame wake
// - delimiter error sets status bit 7
// - bad frame check sets status bit 6
// - password attack sets status bit 5
// - valid unicast sets status bit 4
// - valid broadcast sets status bit 2
// - valid pattern frame sets status bit 1
// - valid magic frame sets status bit 0
module wrf_filter
  import wrf_pkg::*;
(
  input wire logic clk,                   // 100 MHz clock
  input wire logic resetn,                // Async reset, active low
  input wire logic [11:0] address,        // Avalon byte address
  input wire logic read,                  // Avalon read
  input wire logic write,                 // Avalon write
  input wire logic [31:0] writedata,      // Avalon write data
  input wire logic [3:0] byteenable,      // Avalon byte lanes
  output logic [31:0] readdata,           // Avalon read data
  output logic waitrequest,               // Avalon stall
  input wire wrf_rx_ev_t rx_ev,           // Parser event pulses
  output logic wake_out,                  // Wake output
  output logic extended_receive_features_en, // Feature enable to parser
  output logic wake_password_check_en,    // Password check to parser
  output logic [15:0] dsp_tuning_config,  // Tuning word to DSP
  output logic [9:0] feedforward_equalizer_field // Equalizer setting
);

  // Bus handshake state
  logic ack;                // Second cycle of an access
  logic [9:0] idx;          // Word index of the access
  wire req = read | write;  // Any access pending
  wire wr_acc = write & ack;
  wire rd_acc = read & ack;

  // Register storage
  logic [15:0] cfg;         // Receive configuration, clear bit never stored
  logic [7:0] sts;          // Receive status flags
  logic [15:0] dsp;         // DSP tuning word
  logic [9:0] ffe;          // Equalizer field
  logic [6:0] cnt;          // Pulse countdown
  logic level;              // Latched level wake
  logic wake;               // Registered wake output

  // Next values
  logic [15:0] next_cfg;
  logic [7:0] next_sts;
  logic [15:0] next_dsp;
  logic [9:0] next_ffe;
  logic [6:0] next_cnt;
  logic next_level;
  logic next_wake;
  logic [31:0] next_rdata;

  // Byte-lane merge for 16-bit registers in the low lanes
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Pulse length in our clock cycles, rounded up as a least time
  function automatic logic [6:0] pulse_cycles(input logic [1:0] sel);
    int ps;
    ps = (`WRF_STRETCH_BASE << sel) * `WRF_WAKE_CLK_PS;
    return 7'((ps + `WRF_CLK_PS - 1) / `WRF_CLK_PS);
  endfunction

  // Address decode
  assign idx = address[11:2];
  wire hit_dsp = (idx == `WRF_IDX_DSP);
  wire hit_ffe = (idx == `WRF_IDX_FFE);
  wire hit_cfg = (idx == `WRF_IDX_CFG);
  wire hit_sts = (idx == `WRF_IDX_STS);

  // One wait state: the master sees waitrequest low on the second cycle
  assign waitrequest = req & ~ack;

  // Configuration fields
  wire [1:0] stretch = cfg[`WRF_CFG_STR_HI:`WRF_CFG_STR_LO];
  wire wrf_mode_t mode = wrf_mode_t'(cfg[`WRF_CFG_MODE]);
  wire ext_en = cfg[`WRF_CFG_EXT];
  wire pw_en = cfg[`WRF_CFG_PW];

  // Events only count while extended features are on
  wire ev_sfd = ext_en & rx_ev.delim_err;
  wire ev_crc = ext_en & rx_ev.bad_crc;
  wire ev_uc = ext_en & rx_ev.ucast;
  wire ev_bc = ext_en & rx_ev.bcast;
  wire ev_pat = ext_en & rx_ev.pattern;
  // A magic frame is valid unless the password check rejects it
  wire ev_mag = ext_en & rx_ev.magic & (~pw_en | rx_ev.pw_ok);
  // A rejected password marks an attack attempt
  wire ev_hack = ext_en & rx_ev.magic & pw_en & ~rx_ev.pw_ok;

  // Set vector in status layout, reserved bit three stays zero
  wire [7:0] sts_set = {ev_sfd, ev_crc, ev_hack, ev_uc, 1'b0, ev_bc, ev_pat, ev_mag};

  // Only flags already shown to software are cleared by the read
  wire [7:0] sts_clr = (rd_acc & hit_sts) ? readdata[7:0] : 8'h00;

  // Wake trigger from enabled detection events only
  wire wake_uc = ev_uc & cfg[`WRF_CFG_UC];
  wire wake_bc = ev_bc & cfg[`WRF_CFG_BC];
  wire wake_pat = ev_pat & cfg[`WRF_CFG_PAT];
  wire wake_mag = ev_mag & cfg[`WRF_CFG_MAG];
  wire trig = wake_uc | wake_bc | wake_pat | wake_mag;

  // Clear strobe exists only in the write cycle
  wire clr_hit = wr_acc & hit_cfg & byteenable[1] & writedata[`WRF_CFG_CLR];

  // Equalizer write merged over its read-only upper bits; a function result cannot be sliced in place
  wire [15:0] ffe_merged = merge({`WRF_FFE_RSV, ffe}, writedata, byteenable);

  // Register writes
  always_comb begin
    next_cfg = cfg;
    next_dsp = dsp;
    next_ffe = ffe;
    if (wr_acc && hit_cfg) begin
      next_cfg = merge(cfg, writedata, byteenable) & `WRF_CFG_WMASK;
    end else if (wr_acc && hit_dsp) begin
      // Software may load a tuning value for immunity margins
      next_dsp = merge(dsp, writedata, byteenable);
    end else if (wr_acc && hit_ffe) begin
      // Upper bits are read-only, so only the field is kept
      next_ffe = ffe_merged[9:0];
    end
  end

  // Status flags latch; a new event wins over the read clear
  assign next_sts = (sts & ~sts_clr) | sts_set;

  // Wake output machinery for both modes
  always_comb begin
    next_level = 1'b0;
    next_cnt = 7'h00;
    case (mode)
      WRF_LEVEL: begin
        // Held until software clears; a same-cycle event wins
        next_level = trig | (level & ~clr_hit);
      end
      default: begin
        // Retrigger restarts the full pulse
        if (trig) begin
          next_cnt = pulse_cycles(stretch);
        end else if (cnt != 7'h00) begin
          next_cnt = cnt - 7'h01;
        end
      end
    endcase
    next_wake = (mode == WRF_LEVEL) ? next_level : (next_cnt != 7'h00);
  end

  // Read mux; the clear bit always reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_cfg) begin
      next_rdata[15:0] = cfg;
    end else if (hit_sts) begin
      next_rdata[7:0] = sts;
    end else if (hit_dsp) begin
      next_rdata[15:0] = dsp;
    end else if (hit_ffe) begin
      next_rdata[15:0] = {`WRF_FFE_RSV, ffe};
    end
  end

  // Handshake and read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (read && !ack) begin
        readdata <= next_rdata;
      end
    end
  end

  // Register file
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= `WRF_CFG_RST;
      sts <= 8'h00;
      dsp <= `WRF_DSP_RST;
      ffe <= `WRF_FFE_RST;
    end else begin
      cfg <= next_cfg;
      sts <= next_sts;
      dsp <= next_dsp;
      ffe <= next_ffe;
    end
  end

  // Wake state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 7'h00;
      level <= 1'b0;
      wake <= 1'b0;
    end else begin
      cnt <= next_cnt;
      level <= next_level;
      wake <= next_wake;
    end
  end

  // Outputs
  assign wake_out = wake;
  assign extended_receive_features_en = ext_en;
  assign wake_password_check_en = pw_en;
  assign dsp_tuning_config = dsp;
  assign feedforward_equalizer_field = ffe;

  // Helper: length of the current high run of the wake output
  logic [7:0] hi_run;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_run <= 8'h00;
    end else begin
      hi_run <= wake ? 8'(hi_run + 8'h01) : 8'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Level wake up, then a clear write with no new event
  sequence s_level_clear;
    mode == WRF_LEVEL && wake_out && clr_hit && !trig;
  endsequence

  property p_level_clear;
    // A fresh enabled event right after the clear may raise it again
    s_level_clear |=> !wake_out ##1 (!wake_out || $past(trig));
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("level wake not cleared");

  // Pulse never shorter than the programmed width
  property p_pulse_width;
    $fell(wake_out) && mode == WRF_PULSE && $stable(cfg) |->
      hi_run >= 8'(pulse_cycles($past(stretch)));
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("wake pulse too short");

  // Pulse ends in time when no new event arrives
  sequence s_pulse_start;
    mode == WRF_PULSE && trig && stretch == 2'b00;
  endsequence

  property p_pulse_end;
    s_pulse_start ##1 (!trig && $stable(cfg)) [*7] |=> !wake_out;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("wake pulse too long");

  // Level wake holds until cleared
  property p_level_hold;
    mode == WRF_LEVEL && $stable(cfg) && wake_out && !clr_hit |=> wake_out;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level wake dropped");

  // No flag rises while extended features are off
  property p_ext_gate;
    !ext_en |=> (sts & ~$past(sts)) == 8'h00;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("flag set while disabled");

  // Helper: magic wake trigger one cycle late
  logic wake_mag_d;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_mag_d <= 1'b0;
    end else begin
      wake_mag_d <= wake_mag;
    end
  end

  // Rejected password marks an attack and no valid magic frame
  property p_hack;
    ext_en && pw_en && rx_ev.magic && !rx_ev.pw_ok && !rx_ev.ucast && !rx_ev.bcast && !rx_ev.pattern |=>
      sts[`WRF_STS_HACK] && !wake_mag_d;
  endproperty
  a_hack: assert property (p_hack) else $error("attack flag missing");

  // Enabled unicast or broadcast wakes the output next cycle
  property p_uc_bc_wake;
    ext_en && ((rx_ev.ucast && cfg[`WRF_CFG_UC]) || (rx_ev.bcast && cfg[`WRF_CFG_BC])) |=> wake_out;
  endproperty
  a_uc_bc_wake: assert property (p_uc_bc_wake) else $error("unicast or broadcast wake missing");

  // Enabled pattern or valid magic wakes the output next cycle
  property p_pat_mag_wake;
    ext_en && ((rx_ev.pattern && cfg[`WRF_CFG_PAT]) || (ev_mag && cfg[`WRF_CFG_MAG])) |=> wake_out;
  endproperty
  a_pat_mag_wake: assert property (p_pat_mag_wake) else $error("pattern or magic wake missing");

  // Error events set their flags
  property p_err_flags;
    ext_en && (rx_ev.delim_err || rx_ev.bad_crc) |=>
      ($past(rx_ev.delim_err) -> sts[`WRF_STS_SFD]) && ($past(rx_ev.bad_crc) -> sts[`WRF_STS_CRC]);
  endproperty
  a_err_flags: assert property (p_err_flags) else $error("error flag missing");

  // Receive events set their flags
  property p_rx_flags;
    ext_en |=> ($past(rx_ev.ucast) -> sts[`WRF_STS_UC]) && ($past(rx_ev.bcast) -> sts[`WRF_STS_BC]) &&
      ($past(rx_ev.pattern) -> sts[`WRF_STS_PAT]) && ($past(ev_mag) -> sts[`WRF_STS_MAG]);
  endproperty
  a_rx_flags: assert property (p_rx_flags) else $error("receive flag missing");

  // Flags hold until a status read and reserved bit stays zero
  property p_flag_hold;
    !(rd_acc && hit_sts) |=> ((sts & $past(sts)) == $past(sts)) && !sts[3];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");

  // Wake never rises without an enabled event
  property p_no_spurious;
    !trig && !wake_out |=> !wake_out;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("spurious wake");

  // A status read drops every flag it showed when nothing new arrives
  property p_read_clear;
    rd_acc && hit_sts && sts_set == 8'h00 |=> (sts & $past(readdata[7:0])) == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status flag not cleared by read");

  // With features off no event can start a wake
  property p_feature_gate;
    !ext_en && !wake_out |=> !wake_out;
  endproperty
  a_feature_gate: assert property (p_feature_gate) else $error("wake while features off");

  // Clear bit leaves a running pulse alone; it only acts in level mode
  property p_pulse_ignores_clear;
    mode == WRF_PULSE && clr_hit && cnt > 7'h01 |=> wake_out;
  endproperty
  a_pulse_ignores_clear: assert property (p_pulse_ignores_clear) else $error("pulse cut by clear");

  // Password check off: every magic frame is valid and never an attack
  property p_magic_open;
    ext_en && !pw_en && rx_ev.magic |=> sts[`WRF_STS_MAG] && !$rose(sts[`WRF_STS_HACK]);
  endproperty
  a_magic_open: assert property (p_magic_open) else $error("magic frame refused without check");

  // Attack flag rises only for a rejected password with the check on
  property p_hack_only;
    !(ext_en && pw_en && rx_ev.magic && !rx_ev.pw_ok) |=> !$rose(sts[`WRF_STS_HACK]);
  endproperty
  a_hack_only: assert property (p_hack_only) else $error("attack flag without attack");

endmodule // wrf_filter

// File: design/wrf_defines.svh
// Register map, field positions, reset values and timing for the wake receive filter
`ifndef WRF_DEFINES_SVH
`define WRF_DEFINES_SVH

// Register indices; byte address is four times the index
`define WRF_IDX_DSP 10'h100
`define WRF_IDX_FFE 10'h12C
`define WRF_IDX_CFG 10'h134
`define WRF_IDX_STS 10'h135

// Receive configuration fields
`define WRF_CFG_CLR 11
`define WRF_CFG_STR_HI 10
`define WRF_CFG_STR_LO 9
`define WRF_CFG_MODE 8
`define WRF_CFG_EXT 7
`define WRF_CFG_PW 5
`define WRF_CFG_UC 4
`define WRF_CFG_BC 2
`define WRF_CFG_PAT 1
`define WRF_CFG_MAG 0

// Receive status fields
`define WRF_STS_SFD 7
`define WRF_STS_CRC 6
`define WRF_STS_HACK 5
`define WRF_STS_UC 4
`define WRF_STS_BC 2
`define WRF_STS_PAT 1
`define WRF_STS_MAG 0

// Reset values and masks
`define WRF_CFG_RST 16'h0004
`define WRF_CFG_WMASK 16'h07B7
`define WRF_DSP_RST 16'h0000
`define WRF_FFE_RST 10'h000
`define WRF_FFE_RSV 6'h03

// Pulse timing: base width in wake-clock periods, periods in ps
`define WRF_STRETCH_BASE 8
`define WRF_WAKE_CLK_PS 8000
`define WRF_CLK_PS 10000

`endif

// File: design/wrf_pkg.sv
// Types shared by the wake receive filter
package wrf_pkg;

  // Detection events from the frame parser, one-cycle pulses
  typedef struct packed {
    logic delim_err;  // Start delimiter not as expected
    logic bad_crc;  // Frame check failed
    logic ucast;    // Valid unicast frame
    logic bcast;    // Valid broadcast frame
    logic pattern;  // Valid frame holding the pattern
    logic magic;    // Magic frame seen
    logic pw_ok;    // Password in magic frame matched
  } wrf_rx_ev_t;

  // Wake output drive mode
  typedef enum logic {WRF_PULSE, WRF_LEVEL} wrf_mode_t;

endpackage

// File: dv/wrf_wake_host.sv
// Host-side model that watches the wake output and measures pulse widths
`timescale 1ns/1ps
module wrf_wake_host (
  input wire logic clk,           // System clock
  input wire logic resetn,        // Async reset, active low
  input wire logic wake_out,      // Wake line from the filter
  output logic [7:0] last_width   // Length of the last finished pulse
);
  logic [7:0] run_len; // Cycles high so far

  // Count high cycles; a level wake also reports its width once a clear drops it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_len <= 8'h00;
      last_width <= 8'h00;
    end else if (wake_out) begin
      run_len <= run_len + 8'h01;
    end else begin
      if (run_len != 8'h00) begin // Falling edge ends a pulse
        last_width <= run_len;
      end
      run_len <= 8'h00;
    end
  end
endmodule // wrf_wake_host

// File: dv/wrf_filter_test.sv
// Self-checking testbench for the wake receive filter
`timescale 1ns/1ps
module wrf_filter_test
  import wrf_pkg::*;
;
  logic clk, resetn, read, write, wake_out, ext_en, pw_en;
  logic [11:0] address;
  logic [31:0] writedata, readdata, q;
  logic waitrequest;
  logic [15:0] dsp;
  logic [9:0] ffe;
  logic [7:0] width;
  wrf_rx_ev_t rx_ev;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [6:0] ev_tab [6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02};
  logic [15:0] sts_tab [6] = '{16'h0080, 16'h0040, 16'h0010, 16'h0004, 16'h0002, 16'h0001};
  logic [7:0] w_tab [4] = '{8'h07, 8'h0D, 8'h1A, 8'h34};
  logic [6:0] lv_ev [4] = '{7'h02, 7'h04, 7'h08, 7'h10};
  int lv_bit [4] = '{0, 1, 2, 4};

  wrf_filter u_wrf_filter (.clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h3), .readdata(readdata), .waitrequest(waitrequest),
    .rx_ev(rx_ev), .wake_out(wake_out), .extended_receive_features_en(ext_en),
    .wake_password_check_en(pw_en), .dsp_tuning_config(dsp), .feedforward_equalizer_field(ffe));
  wrf_wake_host u_wrf_wake_host (.clk(clk), .resetn(resetn), .wake_out(wake_out), .last_width(width));

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short; the whole run needs far fewer cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {16'h0000, d};
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = readdata; // Taken at the accepting edge
    read <= 1'b0;
    write <= 1'b0;
    @(negedge clk); // Let the accepted write settle before outputs are compared
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, exp});
  endtask

  // One-cycle event pulse, then look once outputs have settled
  task automatic fire(input logic [6:0] ev);
    @(posedge clk);
    rx_ev <= wrf_rx_ev_t'(ev);
    @(posedge clk);
    rx_ev <= wrf_rx_ev_t'(7'h00);
    @(negedge clk);
  endtask

  task automatic test_regs();
    rd(12'h4D0, 16'h0004);
    rd(12'h4D4, 16'h0000);
    rd(12'h4B0, 16'h0C00);
    rd(12'h7FC, 16'h0000);
    bus(1'b1, 12'h400, 16'h1027);
    chk(dsp, 16'h1027);
    rd(12'h400, 16'h1027);
    bus(1'b1, 12'h4B0, 16'h0E81);
    chk(ffe, 10'h281);
    rd(12'h4B0, 16'h0E81);
    bus(1'b1, 12'h4D4, 16'hFFFF);
    rd(12'h4D4, 16'h0000);
    bus(1'b1, 12'h4D0, 16'hFFFF);
    rd(12'h4D0, 16'h07B7);
  endtask

  task automatic test_disabled();
    bus(1'b1, 12'h4D0, 16'h0014);
    fire(7'h18);
    chk(wake_out, 1'b0);
    rd(12'h4D4, 16'h0000);
  endtask

  task automatic test_status();
    bus(1'b1, 12'h4D0, 16'h0080);
    chk(ext_en, 1'b1);
    for (int i = 0; i < 6; i++) begin
      fire(ev_tab[i]);
      rd(12'h4D4, sts_tab[i]);
      rd(12'h4D4, 16'h0000);
    end
    bus(1'b1, 12'h4D0, 16'h00A0);
    chk(pw_en, 1'b1);
    fire(7'h02);
    rd(12'h4D4, 16'h0020);
    fire(7'h03);
    rd(12'h4D4, 16'h0001);
  endtask

  task automatic test_pulse();
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 12'h4D0, 16'h0090 | 16'(s << 9));
      fire(7'h10);
      chk(wake_out, 1'b1);
      if (s == 3) begin
        bus(1'b1, 12'h4D0, 16'h0E90);
        chk(wake_out, 1'b1);
      end
      repeat (70) @(posedge clk);
      chk(width, w_tab[s]);
    end
  endtask

  task automatic test_level();
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 12'h4D0, 16'h0180);
      fire(lv_ev[i]);
      chk(wake_out, 1'b0);
      bus(1'b1, 12'h4D0, 16'h0180 | 16'(1 << lv_bit[i]));
      fire(lv_ev[i]);
      chk(wake_out, 1'b1);
      repeat (70) @(posedge clk);
      chk(wake_out, 1'b1);
      bus(1'b1, 12'h4D0, 16'h0980);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(wake_out, 1'b0);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 12'h000;
    writedata = 32'h00000000;
    rx_ev = wrf_rx_ev_t'(7'h00);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    test_regs();
    test_disabled();
    test_status();
    test_pulse();
    test_level();
    tally_and_finish();
  end
endmodule // wrf_filter_test
